//--- design/reset_cause_regs.svh
`ifndef RESET_CAUSE_REGS_SVH
`define RESET_CAUSE_REGS_SVH

// ********************************
// register offsets (byte addresses)
// ********************************
`define RC_ADDR_W 12
`define RC_OFF_CAUSE 12'h000
`define RC_OFF_CTRL 12'h004
`define RC_OFF_STAT 12'h008
`define RC_OFF_PC 12'h00C
`define RC_OFF_IRQ_STAT 12'h010
`define RC_OFF_IRQ_MASK 12'h014

// ********************************
// field positions
// ********************************
`define RC_BIT_BROWNOUT 0
`define RC_BIT_POR 1
`define RC_BIT_TIMEOUT 0
`define RC_BIT_POWERDOWN 1
`define RC_BIT_HOLD 2
`define RC_BIT_SLEEP 0
`define RC_BIT_PUP_DIS 1
`define RC_BIT_BROWNOUT_EN 2
`define RC_OSC_LSB 4
`define RC_IRQ_RELEASE 0
`define RC_IRQ_CAUSE 1

// ********************************
// reset values
// ********************************
`define RC_CTRL_RST 8'h00
`define RC_MASK_RST 8'h00

// ********************************
// addresses and timing
// ********************************
`define RC_PC_W 13
`define RC_VEC_RESET 13'h0000
`define RC_VEC_IRQ 13'h0004
`define RC_CLK_MHZ 50
`define RC_CPU_START_NS 10000
`define RC_CPU_START_CYC ((`RC_CPU_START_NS * `RC_CLK_MHZ) / 1000)
`define RC_PUP_MS 72
`define RC_PUP_CYC (`RC_PUP_MS * `RC_CLK_MHZ * 1000)
`define RC_OSC_START_CYC 1024

`endif

//--- design/reset_cause_pkg.sv
package reset_cause_pkg;

    typedef enum logic [2:0] {
        OSC_XTAL_LOW = 3'h0,
        OSC_XTAL_STD = 3'h1,
        OSC_XTAL_FAST = 3'h2,
        OSC_EXT_CLOCK = 3'h3,
        OSC_INT_RC = 3'h4,
        OSC_INT_RC_CLKO = 3'h5,
        OSC_EXT_RC = 3'h6,
        OSC_EXT_RC_CLKO = 3'h7
    } osc_mode_t;

    typedef enum logic [3:0] {
        EV_POR = 4'h0,
        EV_BROWNOUT = 4'h1,
        EV_PIN_CLEAR = 4'h2,
        EV_DOG_RESET = 4'h3,
        EV_DOG_WAKE = 4'h4,
        EV_IRQ_WAKE = 4'h5,
        EV_NONE = 4'hF
    } event_t;

    typedef enum logic [4:0] {
        ST_RUN = 5'b00001,
        ST_PUP = 5'b00010,
        ST_OSC = 5'b00100,
        ST_CPU = 5'b01000,
        ST_PIN = 5'b10000
    } seq_state_t;

endpackage

//--- design/sync_2ff.sv
`timescale 1ns/1ps

module sync_2ff #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] async,
    output logic [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] synced_nxt;

    always_comb begin
        meta_nxt = async;
        synced_nxt = meta_r;
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            meta_r <= RESET_VAL;
            synced <= RESET_VAL;
        end else begin
            meta_r <= meta_nxt;
            synced <= synced_nxt;
        end
    end
endmodule

//--- design/delay_counter.sv
`timescale 1ns/1ps

module delay_counter #(
    parameter int WIDTH = 32
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic load,
    input wire logic [WIDTH-1:0] count,
    input wire logic tick,
    output logic done
);
    logic [WIDTH-1:0] remain_r;
    logic [WIDTH-1:0] remain_nxt;
    logic done_nxt;

    always_comb begin
        remain_nxt = remain_r;
        if (load) begin
            remain_nxt = count;
        end else if (tick && remain_r != '0) begin
            remain_nxt = remain_r - 1'b1;
        end
        done_nxt = !load && (remain_nxt == '0);
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            remain_r <= '0;
            done <= 1'b0;
        end else begin
            remain_r <= remain_nxt;
            done <= done_nxt;
        end
    end
endmodule

//--- design/reset_cause_and_startup.sv
`timescale 1ns/1ps
`include "reset_cause_regs.svh"

module reset_cause_and_startup
    import reset_cause_pkg::*;
#(
    parameter int PUP_CYC = `RC_PUP_CYC,
    parameter int OSC_START_CYC = `RC_OSC_START_CYC
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic porEvent,
    input wire logic borEvent,
    input wire logic masterClearPinN,
    input wire logic dogTimeout,
    input wire logic irqWake,
    input wire logic globalIrqEnable,
    input wire logic oscTick,
    input wire logic [`RC_PC_W-1:0] sleepPc,
    output logic cpuHoldReset,
    output logic [`RC_PC_W-1:0] startPc,
    output logic startPcValid,
    output logic irq
);
    localparam int CPU_CYC = (`RC_CPU_START_CYC < 1) ? 1 : `RC_CPU_START_CYC;

    // ********************************
    // pin synchronisers
    // ********************************
    logic [5:0] pinsSync;
    logic porS, brownS, clearNS, dogS, wakeS, oscS;
    // clear pin idles high: its stage resets high, else nrst looks like a pin reset
    sync_2ff #(.WIDTH(6), .RESET_VAL(6'h08)) pinSync (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .async({porEvent, borEvent, masterClearPinN, dogTimeout, irqWake, oscTick}),
        .synced(pinsSync)
    );
    assign {porS, brownS, clearNS, dogS, wakeS, oscS} = pinsSync;

    logic dogPrev_r, oscPrev_r, wakePrev_r, dogPrev_nxt, oscPrev_nxt, wakePrev_nxt;
    logic dogRise, oscRise, wakeRise;
    always_comb begin
        dogPrev_nxt = dogS;
        oscPrev_nxt = oscS;
        wakePrev_nxt = wakeS;
        dogRise = dogS && !dogPrev_r;
        oscRise = oscS && !oscPrev_r;
        wakeRise = wakeS && !wakePrev_r;
    end
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            dogPrev_r <= 1'b0;
            oscPrev_r <= 1'b0;
            wakePrev_r <= 1'b0;
        end else begin
            dogPrev_r <= dogPrev_nxt;
            oscPrev_r <= oscPrev_nxt;
            wakePrev_r <= wakePrev_nxt;
        end
    end

    // ********************************
    // registers
    // ********************************
    logic [1:0] cause_r, cause_nxt;
    logic [1:0] status_r, status_nxt;
    logic [7:0] ctrl_r, ctrl_nxt;
    logic [1:0] irqStat_r, irqStat_nxt;
    logic [1:0] irqMask_r, irqMask_nxt;
    logic [31:0] prdata_nxt;
    logic pslverr_nxt, irq_nxt;
    seq_state_t state_r, state_nxt;
    logic [`RC_PC_W-1:0] startPc_nxt;
    logic startPcValid_nxt, hold_nxt;
    logic isCrystal, pupOn;
    logic [31:0] loadCount;
    logic loadPup, loadOsc, loadCpu, pupDone, oscDone, cpuDone;
    event_t ev;

    logic apbWr, apbRd, apbSetup, mapped;
    logic releaseEv;
    osc_mode_t oscMode;
    assign apbWr = psel && penable && pwrite;
    assign apbSetup = psel && !penable;
    assign apbRd = apbSetup && !pwrite;
    assign mapped = (paddr == `RC_OFF_CAUSE) || (paddr == `RC_OFF_CTRL) || (paddr == `RC_OFF_STAT)
        || (paddr == `RC_OFF_PC) || (paddr == `RC_OFF_IRQ_STAT) || (paddr == `RC_OFF_IRQ_MASK);
    assign oscMode = osc_mode_t'(ctrl_r[`RC_OSC_LSB +: 3]);

    // ********************************
    // event decode, priority highest first
    // ********************************
    always_comb begin
        ev = EV_NONE;
        if (porS) begin
            ev = EV_POR;
        end else if (brownS && ctrl_r[`RC_BIT_BROWNOUT_EN]) begin
            ev = EV_BROWNOUT;
        end else if (!clearNS) begin
            ev = EV_PIN_CLEAR;
        end else if (dogRise) begin
            ev = ctrl_r[`RC_BIT_SLEEP] ? EV_DOG_WAKE : EV_DOG_RESET;
        end else if (wakeRise && ctrl_r[`RC_BIT_SLEEP]) begin
            ev = EV_IRQ_WAKE;
        end
    end

    // ********************************
    // start-up sequencer
    // ********************************
    always_comb begin
        isCrystal = (oscMode == OSC_XTAL_LOW) || (oscMode == OSC_XTAL_STD) || (oscMode == OSC_XTAL_FAST);
        pupOn = !ctrl_r[`RC_BIT_PUP_DIS];
        state_nxt = state_r;
        startPc_nxt = startPc;
        startPcValid_nxt = 1'b0;
        loadPup = 1'b0;
        loadOsc = 1'b0;
        loadCpu = 1'b0;
        releaseEv = 1'b0;
        case (ev)
            EV_POR, EV_BROWNOUT: begin
                startPc_nxt = `RC_VEC_RESET;
                if (pupOn) begin
                    state_nxt = ST_PUP;
                    loadPup = 1'b1;
                end else if (isCrystal) begin
                    state_nxt = ST_OSC;
                    loadOsc = 1'b1;
                end else begin
                    state_nxt = ST_CPU;
                    loadCpu = 1'b1;
                end
            end
            EV_PIN_CLEAR: begin
                startPc_nxt = `RC_VEC_RESET;
                state_nxt = ST_PIN;
            end
            EV_DOG_RESET: begin
                startPc_nxt = `RC_VEC_RESET;
                state_nxt = ST_CPU;
                loadCpu = 1'b1;
            end
            EV_DOG_WAKE, EV_IRQ_WAKE: begin
                // vector only for an irq wake with global enable
                startPc_nxt = (ev == EV_IRQ_WAKE && globalIrqEnable) ? `RC_VEC_IRQ : sleepPc + 1'b1;
                state_nxt = isCrystal ? ST_OSC : ST_CPU;
                loadOsc = isCrystal;
                loadCpu = !isCrystal;
            end
            default: begin
                case (state_r)
                    ST_PUP: begin
                        if (pupDone) begin
                            state_nxt = isCrystal ? ST_OSC : ST_RUN;
                            loadOsc = isCrystal;
                            releaseEv = !isCrystal;
                        end
                    end
                    ST_OSC: begin
                        if (oscDone) begin
                            state_nxt = ST_RUN;
                            releaseEv = 1'b1;
                        end
                    end
                    ST_CPU: begin
                        if (cpuDone) begin
                            state_nxt = ST_RUN;
                            releaseEv = 1'b1;
                        end
                    end
                    ST_PIN: begin
                        // pin release starts execution at once
                        state_nxt = ST_RUN;
                        releaseEv = 1'b1;
                    end
                    default: state_nxt = ST_RUN;
                endcase
            end
        endcase
        startPcValid_nxt = releaseEv;
        hold_nxt = (state_nxt != ST_RUN);
        loadCount = loadPup ? 32'(PUP_CYC) : loadOsc ? 32'(OSC_START_CYC) : 32'(CPU_CYC);
    end

    // one shared counter times cpu start-up and both other delays, cpu start-up the shortest by default
    delay_counter #(.WIDTH(32)) mainDelay (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .load(loadPup || loadOsc || loadCpu),
        .count(loadCount),
        .tick((state_r == ST_OSC) ? oscRise : 1'b1),
        .done(cpuDone)
    );
    assign pupDone = cpuDone;
    assign oscDone = cpuDone;

    // ********************************
    // flags, control and bus
    // ********************************
    always_comb begin
        cause_nxt = cause_r;
        status_nxt = status_r;
        ctrl_nxt = ctrl_r;
        irqStat_nxt = irqStat_r;
        irqMask_nxt = irqMask_r;
        prdata_nxt = 32'h0000_0000;
        pslverr_nxt = apbSetup && !mapped;
        if (apbWr) begin
            if (paddr == `RC_OFF_CAUSE) begin
                cause_nxt = pwdata[1:0];
            end else if (paddr == `RC_OFF_CTRL) begin
                ctrl_nxt = pwdata[7:0];
            end else if (paddr == `RC_OFF_IRQ_STAT) begin
                irqStat_nxt = irqStat_r & ~pwdata[1:0];
            end else if (paddr == `RC_OFF_IRQ_MASK) begin
                irqMask_nxt = pwdata[1:0];
            end
        end
        // decoded in setup so data and refusal stand together with pready
        if (apbRd) begin
            if (paddr == `RC_OFF_CAUSE) begin
                prdata_nxt = {30'h0, cause_r};
            end else if (paddr == `RC_OFF_CTRL) begin
                prdata_nxt = {24'h0, ctrl_r};
            end else if (paddr == `RC_OFF_STAT) begin
                prdata_nxt = {29'h0, cpuHoldReset, status_r};
            end else if (paddr == `RC_OFF_PC) begin
                prdata_nxt = {19'h0, startPc};
            end else if (paddr == `RC_OFF_IRQ_STAT) begin
                prdata_nxt = {30'h0, irqStat_r};
            end else if (paddr == `RC_OFF_IRQ_MASK) begin
                prdata_nxt = {30'h0, irqMask_r};
            end
        end
        // hardware events win over software writes
        case (ev)
            EV_POR: begin
                cause_nxt[`RC_BIT_POR] = 1'b0;
                status_nxt = 2'b11;
                ctrl_nxt[`RC_BIT_SLEEP] = 1'b0;
            end
            EV_BROWNOUT: begin
                cause_nxt[`RC_BIT_BROWNOUT] = 1'b0;
                status_nxt = 2'b11;
                ctrl_nxt[`RC_BIT_SLEEP] = 1'b0;
            end
            EV_PIN_CLEAR: begin
                if (ctrl_r[`RC_BIT_SLEEP]) begin
                    status_nxt = 2'b01;
                end
                ctrl_nxt[`RC_BIT_SLEEP] = 1'b0;
            end
            EV_DOG_RESET: status_nxt = 2'b10;
            EV_DOG_WAKE: begin
                status_nxt = 2'b00;
                ctrl_nxt[`RC_BIT_SLEEP] = 1'b0;
            end
            EV_IRQ_WAKE: begin
                status_nxt = 2'b01;
                ctrl_nxt[`RC_BIT_SLEEP] = 1'b0;
            end
            default: ;
        endcase
        if (releaseEv) begin
            irqStat_nxt[`RC_IRQ_RELEASE] = 1'b1;
        end
        if (ev != EV_NONE) begin
            irqStat_nxt[`RC_IRQ_CAUSE] = 1'b1;
        end
        irq_nxt = |(irqStat_nxt & irqMask_nxt);
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            cause_r <= 2'b11;
            status_r <= 2'b11;
            ctrl_r <= `RC_CTRL_RST;
            irqStat_r <= 2'b00;
            irqMask_r <= 2'b00;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready <= 1'b0;
            irq <= 1'b0;
            state_r <= ST_RUN;
            startPc <= `RC_VEC_RESET;
            startPcValid <= 1'b0;
            cpuHoldReset <= 1'b0;
        end else begin
            cause_r <= cause_nxt;
            status_r <= status_nxt;
            ctrl_r <= ctrl_nxt;
            irqStat_r <= irqStat_nxt;
            irqMask_r <= irqMask_nxt;
            prdata <= prdata_nxt;
            pslverr <= pslverr_nxt;
            pready <= psel && !penable;
            irq <= irq_nxt;
            state_r <= state_nxt;
            startPc <= startPc_nxt;
            startPcValid <= startPcValid_nxt;
            cpuHoldReset <= hold_nxt;
        end
    end
endmodule

//--- verification/reset_cause_and_startup_asserts.sv
`timescale 1ns/1ps
module reset_cause_and_startup_asserts (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic porEvent,
    input wire logic dogTimeout,
    input wire logic masterClearPinN,
    input wire logic cpuHoldReset,
    input wire logic startPcValid
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    AST_PREADY_NEXT: assert property (psel && !penable |=> pready)
        else $error("no answer in access cycle");
    AST_PREADY_ACCESS: assert property (pready |-> psel && penable)
        else $error("answer outside access");
    AST_ERR_UNMAPPED: assert property (psel && !penable && paddr > 12'h014 |=> pslverr)
        else $error("unmapped access not refused");
    AST_ERR_ONLY: assert property (pslverr |-> pready && paddr > 12'h014)
        else $error("error on mapped access");
    AST_VALID_PULSE: assert property (startPcValid |=> !startPcValid)
        else $error("start pulse too long");
    AST_VALID_AFTER_HOLD: assert property (startPcValid |-> $past(cpuHoldReset))
        else $error("start pulse without hold");
    AST_PIN_HOLD: assert property (!masterClearPinN [*5] |-> cpuHoldReset && !startPcValid)
        else $error("core runs while pin low");
    AST_POR_HOLD: assert property ($rose(porEvent) |-> ##[1:5] cpuHoldReset)
        else $error("power-on not held");
    AST_DOG_HOLD: assert property ($rose(dogTimeout) |-> ##[1:6] cpuHoldReset)
        else $error("dog event not held");
endmodule

//--- verification/test_reset_cause_and_startup.sv
`timescale 1ns/1ps
`include "reset_cause_regs.svh"
module test_reset_cause_and_startup;
    // ********************
    // stimulus and design
    // ********************
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic porEvent = 1'b0;
    logic borEvent = 1'b0;
    logic masterClearPinN = 1'b1;
    logic dogTimeout = 1'b0;
    logic irqWake = 1'b0;
    logic globalIrqEnable = 1'b0;
    logic oscTick = 1'b0;
    logic [12:0] sleepPc = 13'h0000;
    logic [31:0] prdata;
    logic pready, pslverr, cpuHoldReset, startPcValid, irq, ok;
    logic [12:0] startPc, lastPc;
    int error_cnt = 0;
    int n_checks = 0;
    int hc;

    always #10 clk_sys = ~clk_sys;

    // short counts keep the run brief
    reset_cause_and_startup #(.PUP_CYC(50), .OSC_START_CYC(8)) uut (
        .clk_sys(clk_sys), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .porEvent(porEvent), .borEvent(borEvent), .masterClearPinN(masterClearPinN),
        .dogTimeout(dogTimeout), .irqWake(irqWake), .globalIrqEnable(globalIrqEnable),
        .oscTick(oscTick), .sleepPc(sleepPc), .cpuHoldReset(cpuHoldReset), .startPc(startPc),
        .startPcValid(startPcValid), .irq(irq)
    );

    // ********************
    // shared tasks
    // ********************
    task automatic test_done();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
        if (n >= 16) begin
            chk("pready wait", 1, 0);
            test_done();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(nm, exp, r & m);
    endtask

    // level pins stay active ten cycles, edge pins rise once
    task automatic fire(input int k);
        case (k)
            0: porEvent <= 1'b1;
            1: borEvent <= 1'b1;
            2: dogTimeout <= 1'b1;
            3: irqWake <= 1'b1;
            default: masterClearPinN <= 1'b0;
        endcase
        repeat (10) @(posedge clk_sys);
        porEvent <= 1'b0;
        borEvent <= 1'b0;
        dogTimeout <= 1'b0;
        irqWake <= 1'b0;
        masterClearPinN <= 1'b1;
    endtask

    task automatic seq_wait(input int lim, input logic tk, input logic must);
        hc = 0;
        ok = 1'b0;
        for (int n = 0; n < lim && !ok; n++) begin
            @(posedge clk_sys);
            if (tk) oscTick <= ~oscTick;
            if (cpuHoldReset === 1'b1) hc++;
            if (startPcValid === 1'b1) begin
                ok = 1'b1;
                lastPc = startPc;
            end
        end
        if (must && !ok) begin
            chk("release", 1, 0);
            test_done();
        end
    endtask

    // ********************
    // scenarios
    // ********************
    task automatic t_regs();
        logic [31:0] r;
        logic e;
        rdc("cause rst", `RC_OFF_CAUSE, ALL, 32'h3);
        rdc("stat rst", `RC_OFF_STAT, ALL, 32'h3);
        rdc("ctrl rst", `RC_OFF_CTRL, ALL, 32'h0);
        rdc("mask rst", `RC_OFF_IRQ_MASK, ALL, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wr(`RC_OFF_CAUSE, 32'hFFFFFFF0 | 32'(i));
            rdc("cause rw", `RC_OFF_CAUSE, ALL, 32'(i));
        end
        wr(`RC_OFF_STAT, 32'h0);
        rdc("stat ro", `RC_OFF_STAT, ALL, 32'h3);
        apb(1'b0, 12'h018, 32'h0, r, e);
        chk("unmapped err", 1, 32'(e));
        chk("unmapped data", 0, r);
    endtask

    task automatic t_dog();
        fire(2);
        seq_wait(600, 1'b0, 1'b1);
        chk("dog pc", 0, 32'(lastPc));
        rdc("dog stat", `RC_OFF_STAT, ALL, 32'h2);
        rdc("dog cause", `RC_OFF_CAUSE, ALL, 32'h3);
    endtask

    task automatic t_pin_run();
        fire(4);
        seq_wait(100, 1'b0, 1'b1);
        chk("pin pc", 0, 32'(lastPc));
        rdc("pin stat", `RC_OFF_STAT, ALL, 32'h2);
        rdc("pin cause", `RC_OFF_CAUSE, ALL, 32'h3);
    endtask

    task automatic t_por();
        wr(`RC_OFF_CTRL, 32'h40);
        fire(0);
        seq_wait(600, 1'b0, 1'b1);
        chk("powerup_timer hold", 1, 32'(hc >= 40 && hc <= 120));
        rdc("por flag", `RC_OFF_CAUSE, 32'h2, 32'h0);
        rdc("por stat", `RC_OFF_STAT, ALL, 32'h3);
        wr(`RC_OFF_CAUSE, 32'h3);
        rdc("cause set", `RC_OFF_CAUSE, ALL, 32'h3);
    endtask

    task automatic t_bor();
        wr(`RC_OFF_CTRL, 32'h36);
        fire(1);
        seq_wait(600, 1'b0, 1'b1);
        chk("cpu delay", 1, 32'(hc >= 240 && hc <= 520));
        rdc("bor flag", `RC_OFF_CAUSE, ALL, 32'h2);
        rdc("bor stat", `RC_OFF_STAT, ALL, 32'h3);
        wr(`RC_OFF_CAUSE, 32'h3);
    endtask

    task automatic t_xtal();
        wr(`RC_OFF_CTRL, 32'h12);
        fire(0);
        seq_wait(700, 1'b0, 1'b0);
        chk("xtal early", 0, 32'(ok));
        chk("xtal hold", 1, 32'(cpuHoldReset));
        seq_wait(100, 1'b1, 1'b1);
        chk("xtal count", 1, 32'(hc >= 14 && hc <= 60));
        wr(`RC_OFF_CAUSE, 32'h3);
    endtask

    // irq wake plain, irq wake vectored, dog wake, pin reset in sleep
    task automatic t_wake();
        int kind [4] = '{3, 3, 2, 4};
        logic [31:0] est [4] = '{32'h1, 32'h1, 32'h0, 32'h1};
        for (int i = 0; i < 4; i++) begin
            sleepPc <= 13'h0120 + 13'(i);
            globalIrqEnable <= (i == 1);
            wr(`RC_OFF_CTRL, 32'h43);
            fire(kind[i]);
            seq_wait(600, 1'b0, 1'b1);
            chk("wake pc", i == 3 ? 32'h0 : i == 1 ? 32'h4 : 32'h121 + 32'(i), 32'(lastPc));
            rdc("wake stat", `RC_OFF_STAT, ALL, est[i]);
            rdc("wake ctrl", `RC_OFF_CTRL, 32'h73, 32'h42);
            rdc("wake cause", `RC_OFF_CAUSE, ALL, 32'h3);
            if (i < 3) chk("wake delay", 1, 32'(hc >= 240 && hc <= 520));
        end
    endtask

    task automatic t_irq();
        rdc("irq stat", `RC_OFF_IRQ_STAT, ALL, 32'h3);
        chk("irq masked", 0, 32'(irq));
        wr(`RC_OFF_IRQ_MASK, 32'h2);
        chk("irq on", 1, 32'(irq));
        wr(`RC_OFF_IRQ_STAT, 32'h1);
        rdc("w1c one", `RC_OFF_IRQ_STAT, ALL, 32'h2);
        wr(`RC_OFF_IRQ_STAT, 32'h2);
        chk("irq off", 0, 32'(irq));
        wr(`RC_OFF_IRQ_MASK, 32'h1);
        fire(4);
        seq_wait(100, 1'b0, 1'b1);
        repeat (2) @(posedge clk_sys);
        chk("irq release", 1, 32'(irq));
        wr(`RC_OFF_IRQ_MASK, 32'h0);
        chk("irq mask off", 0, 32'(irq));
    endtask

    initial begin
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        t_regs();
        t_dog();
        t_pin_run();
        t_por();
        t_bor();
        t_xtal();
        t_wake();
        t_irq();
        test_done();
    end
endmodule

bind reset_cause_and_startup reset_cause_and_startup_asserts chk_i (
    .clk_sys(clk_sys), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .porEvent(porEvent), .dogTimeout(dogTimeout),
    .masterClearPinN(masterClearPinN), .cpuHoldReset(cpuHoldReset), .startPcValid(startPcValid)
);
